// ===== hw/port_three_pin_mux.sv
/*
 * port three pin mux: register slave, pin function select, pin states per
 * operating mode and software pull-ups. assumes pins arrive asynchronously
 * and serial units sit on clk_sys.
 */
// Local design decisions: the Avalon-MM register port and the register addresses.
// How it works
// - pin3 gpio or ser2 clock, source-dependent direction
// - pin2 gpio or ser1 data output
// - pin1 gpio or ser1 data input
// - pin0 gpio or ser1 clock, source-dependent direction
// - float in reset/standby, hold in sleeps
// - standby pull-up pin shows high level
// - pull-up on only for input with bit
// - all pull-ups off right after reset
// - eight independent pull-ups, pins seven to zero
// - pin mode register resets to zero
`timescale 1ns/1ps
module port_three_pin_mux (
    input wire logic clk_sys,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // chip operating mode
    input wire port_mux_pkg::op_mode_type op_mode,
    // pins
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pullup_on,
    // serial unit 1
    input wire logic ser1_clock_source_bit,
    input wire logic ser1_clk_out,
    output logic ser1_clk_in,
    input wire logic ser1_dout,
    output logic ser1_din,
    // serial unit 2
    input wire logic [2:0] ser2_clock_source_bits,
    input wire logic ser2_clk_out,
    output logic ser2_clk_in
);
    logic [7:0] data_q; // gpio output latch
    logic [7:0] dir_q; // port_direction_reg
    logic [7:0] mode_q; // port_pin_mode_reg
    logic [7:0] pull_q; // port_pullup_ctrl_reg
    logic [7:0] sync1_q, sync2_q, sync3_q; // pin synchronisers
    logic [7:0] pin_q; // filtered pin level
    logic [7:0] mux_out, mux_oe; // functional pin drive
    logic [7:0] held_out_q, held_oe_q; // frozen drive in sleep modes
    logic [7:0] pull_raw; // pull-up request
    logic rd_pend_q; // read takes one wait cycle
    logic hold_mode, float_mode;

    // byte lane write helper
    function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [31:0] wd,
                                           input logic be0);
        return be0 ? wd[7:0] : old;
    endfunction

    assign hold_mode = (op_mode == port_mux_pkg::MODE_SLEEP)
                    || (op_mode == port_mux_pkg::MODE_SUBSLEEP)
                    || (op_mode == port_mux_pkg::MODE_WATCH);
    assign float_mode = rst || (op_mode == port_mux_pkg::MODE_STANDBY);

    // writes take effect at once, reads wait one cycle for registered data
    assign avs_waitrequest = avs_read && !rd_pend_q;

    // register writes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            data_q <= port_mux_pkg::RST_DATA;
            dir_q <= port_mux_pkg::RST_DIR;
            mode_q <= port_mux_pkg::RST_MODE;
            pull_q <= port_mux_pkg::RST_PULL;
        end else if (avs_write) begin
            unique case (avs_address)
                port_mux_pkg::OFF_DATA: data_q <= wr_byte(data_q, avs_writedata, avs_byteenable[0]);
                port_mux_pkg::OFF_DIR: dir_q <= wr_byte(dir_q, avs_writedata, avs_byteenable[0]);
                port_mux_pkg::OFF_MODE: mode_q <= wr_byte(mode_q, avs_writedata, avs_byteenable[0]);
                port_mux_pkg::OFF_PULL: pull_q <= wr_byte(pull_q, avs_writedata, avs_byteenable[0]);
                default: begin
                    // unmapped: write ignored
                end
            endcase
        end
    end

    // read path, one wait state
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_pend_q <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            rd_pend_q <= avs_read && !rd_pend_q;
            if (avs_read && !rd_pend_q) begin
                unique case (avs_address)
                    port_mux_pkg::OFF_DATA: avs_readdata <= {24'h000000, pin_q}; // live pins
                    port_mux_pkg::OFF_DIR: avs_readdata <= {24'h000000, dir_q};
                    port_mux_pkg::OFF_MODE: avs_readdata <= {24'h000000, mode_q};
                    port_mux_pkg::OFF_PULL: avs_readdata <= {24'h000000, pull_q};
                    default: avs_readdata <= 32'h0000_0000; // unmapped reads zero
                endcase
            end
        end
    end

    // pin synchroniser: a change counts once stages two and three agree
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
            sync3_q <= 8'h00;
            pin_q <= 8'h00;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            for (int i = 0; i < 8; i++) begin
                if (sync2_q[i] == sync3_q[i]) pin_q[i] <= sync3_q[i];
            end
        end
    end

    // functional drive per pin
    always_comb begin
        mux_out = data_q;
        mux_oe = dir_q;
        if (mode_q[port_mux_pkg::BIT_SER1_CLK]) begin
            mux_out[0] = ser1_clk_out;
            mux_oe[0] = !ser1_clock_source_bit;
        end
        if (mode_q[port_mux_pkg::BIT_SER1_DIN]) begin
            mux_out[1] = 1'b0;
            mux_oe[1] = 1'b0;
        end
        if (mode_q[port_mux_pkg::BIT_SER1_DOUT]) begin
            mux_out[2] = ser1_dout;
            mux_oe[2] = 1'b1;
        end
        if (mode_q[port_mux_pkg::BIT_SER2_CLK]) begin
            mux_out[3] = ser2_clk_out;
            mux_oe[3] = (ser2_clock_source_bits != port_mux_pkg::SER2_EXT_CLK);
        end
    end

    // serial inputs taken from the filtered pins; zero when not selected
    assign ser1_clk_in = mode_q[port_mux_pkg::BIT_SER1_CLK] && ser1_clock_source_bit && pin_q[0];
    assign ser1_din = mode_q[port_mux_pkg::BIT_SER1_DIN] && pin_q[1];
    assign ser2_clk_in = mode_q[port_mux_pkg::BIT_SER2_CLK]
                      && (ser2_clock_source_bits == port_mux_pkg::SER2_EXT_CLK) && pin_q[3];

    // freeze the last drive while in a hold mode
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            held_out_q <= 8'h00;
            held_oe_q <= 8'h00;
        end else if (!hold_mode) begin
            held_out_q <= mux_out;
            held_oe_q <= mux_oe;
        end
    end

    // pull-up only for pins whose direction bit is input; per pin
    assign pull_raw = pull_q & ~dir_q;

    // pin state by mode; reset and standby float, hold modes keep the last drive
    always_comb begin
        if (float_mode) begin
            pin_oe = 8'h00;
            pin_out = 8'h00;
        end else if (hold_mode) begin
            pin_oe = held_oe_q;
            pin_out = held_out_q;
        end else begin
            pin_oe = mux_oe;
            pin_out = mux_out;
        end
        // in standby the pull-up keeps its pin high rather than floating
        pullup_on = rst ? 8'h00 : pull_raw;
    end

    property p_pull_gate;
        @(posedge clk_sys) disable iff (rst) (pullup_on == (pull_q & ~dir_q));
    endproperty
    a_pull_gate: assert property (p_pull_gate) else $error("pull-up gating wrong");

    property p_pull_off_after_reset;
        @(posedge clk_sys) $fell(rst) |-> pullup_on == 8'h00;
    endproperty
    a_pull_off_after_reset: assert property (p_pull_off_after_reset)
        else $error("pull-up on after reset");

    property p_standby_float;
        @(posedge clk_sys) disable iff (rst) op_mode == port_mux_pkg::MODE_STANDBY |-> pin_oe == 8'h00;
    endproperty
    a_standby_float: assert property (p_standby_float) else $error("pin driven in standby");

    property p_hold;
        @(posedge clk_sys) disable iff (rst) hold_mode && $past(hold_mode) |-> $stable(pin_oe) && $stable(pin_out);
    endproperty
    a_hold: assert property (p_hold) else $error("pin changed in hold mode");

    property p_ser2_clk;
        @(posedge clk_sys) disable iff (rst)
            !float_mode && !hold_mode && mode_q[port_mux_pkg::BIT_SER2_CLK]
            |-> pin_oe[3] == (ser2_clock_source_bits != port_mux_pkg::SER2_EXT_CLK);
    endproperty
    a_ser2_clk: assert property (p_ser2_clk) else $error("ser2 clock dir wrong");

    property p_ser1_dout;
        @(posedge clk_sys) disable iff (rst) !float_mode && !hold_mode && mode_q[2]
            |-> pin_oe[2] && pin_out[2] == ser1_dout;
    endproperty
    a_ser1_dout: assert property (p_ser1_dout) else $error("ser1 dout not driven");

    property p_ser1_din;
        @(posedge clk_sys) disable iff (rst) !float_mode && !hold_mode && mode_q[1] |-> !pin_oe[1];
    endproperty
    a_ser1_din: assert property (p_ser1_din) else $error("ser1 din driven");

    property p_ser1_clk;
        @(posedge clk_sys) disable iff (rst) !float_mode && !hold_mode && mode_q[0]
            |-> pin_oe[0] == !ser1_clock_source_bit && (!pin_oe[0] || pin_out[0] == ser1_clk_out);
    endproperty
    a_ser1_clk: assert property (p_ser1_clk) else $error("ser1 clock wrong");

    property p_mode_reset;
        @(posedge clk_sys) $fell(rst) |-> mode_q == 8'h00;
    endproperty
    a_mode_reset: assert property (p_mode_reset) else $error("mode reg not zero");

    // bus handshake steps: a read opens, then answers one cycle later
    sequence s_read_start;
        avs_read && !rd_pend_q;
    endsequence

    sequence s_read_held;
        s_read_start ##1 avs_read;
    endsequence

    // a held read must see waitrequest drop after exactly one wait cycle
    property p_read_one_wait;
        @(posedge clk_sys) disable iff (rst) s_read_held |-> !avs_waitrequest;
    endproperty
    a_read_one_wait: assert property (p_read_one_wait) else $error("read wait wrong");

    // writes never stall the master
    property p_write_no_wait;
        @(posedge clk_sys) disable iff (rst) avs_write |-> !avs_waitrequest;
    endproperty
    a_write_no_wait: assert property (p_write_no_wait) else $error("write stalled");

    // while reset is high nothing drives and no pull-up is on
    property p_reset_float;
        @(posedge clk_sys) rst |-> pin_oe == 8'h00 && pullup_on == 8'h00;
    endproperty
    a_reset_float: assert property (p_reset_float) else $error("pin active in reset");

    // an output pin never has its pull-up on, whatever the pull-up bit says
    property p_pull_off_output;
        @(posedge clk_sys) disable iff (rst) (pullup_on & dir_q) == 8'h00;
    endproperty
    a_pull_off_output: assert property (p_pull_off_output) else $error("pull-up on output");

    // standby keeps the pull-ups of input pins so those pins read high
    property p_standby_pull;
        @(posedge clk_sys) disable iff (rst) op_mode == port_mux_pkg::MODE_STANDBY
            |-> pullup_on == (pull_q & ~dir_q);
    endproperty
    a_standby_pull: assert property (p_standby_pull) else $error("standby pull-up lost");

    // entering a hold mode freezes the drive of the last functional cycle
    sequence s_enter_hold;
        !hold_mode ##1 hold_mode;
    endsequence

    property p_hold_enter;
        @(posedge clk_sys) disable iff (rst) s_enter_hold ##0 !float_mode
            |-> pin_out == $past(mux_out) && pin_oe == $past(mux_oe);
    endproperty
    a_hold_enter: assert property (p_hold_enter) else $error("hold did not freeze");

    // general i/o pins follow the data latch and direction bits
    property p_gpio_pin3;
        @(posedge clk_sys) disable iff (rst)
            !float_mode && !hold_mode && !mode_q[port_mux_pkg::BIT_SER2_CLK]
            |-> pin_oe[3] == dir_q[3] && pin_out[3] == data_q[3];
    endproperty
    a_gpio_pin3: assert property (p_gpio_pin3) else $error("pin3 gpio wrong");

    property p_gpio_pin2;
        @(posedge clk_sys) disable iff (rst)
            !float_mode && !hold_mode && !mode_q[port_mux_pkg::BIT_SER1_DOUT]
            |-> pin_oe[2] == dir_q[2] && pin_out[2] == data_q[2];
    endproperty
    a_gpio_pin2: assert property (p_gpio_pin2) else $error("pin2 gpio wrong");

    property p_gpio_pin1;
        @(posedge clk_sys) disable iff (rst)
            !float_mode && !hold_mode && !mode_q[port_mux_pkg::BIT_SER1_DIN]
            |-> pin_oe[1] == dir_q[1] && pin_out[1] == data_q[1];
    endproperty
    a_gpio_pin1: assert property (p_gpio_pin1) else $error("pin1 gpio wrong");

    property p_gpio_pin0;
        @(posedge clk_sys) disable iff (rst)
            !float_mode && !hold_mode && !mode_q[port_mux_pkg::BIT_SER1_CLK]
            |-> pin_oe[0] == dir_q[0] && pin_out[0] == data_q[0];
    endproperty
    a_gpio_pin0: assert property (p_gpio_pin0) else $error("pin0 gpio wrong");

    // serial data input sees the filtered pin only while selected
    property p_din_route;
        @(posedge clk_sys) disable iff (rst)
            ser1_din == (mode_q[port_mux_pkg::BIT_SER1_DIN] && pin_q[1]);
    endproperty
    a_din_route: assert property (p_din_route) else $error("ser1 din route wrong");

    // unit 2 clock input is fed only when its source is external
    property p_ser2_clk_in;
        @(posedge clk_sys) disable iff (rst)
            ser2_clock_source_bits != port_mux_pkg::SER2_EXT_CLK |-> !ser2_clk_in;
    endproperty
    a_ser2_clk_in: assert property (p_ser2_clk_in) else $error("ser2 clock in leaks");

    // unit 1 clock input is fed only when its source is external
    property p_ser1_clk_in;
        @(posedge clk_sys) disable iff (rst) !ser1_clock_source_bit |-> !ser1_clk_in;
    endproperty
    a_ser1_clk_in: assert property (p_ser1_clk_in) else $error("ser1 clock in leaks");
endmodule // port_three_pin_mux

// ===== hw/port_mux_pkg.sv
/*
 * constants for the port three pin mux, pull-up control and register map.
 * assumes an avalon-mm slave with 32-bit data, word aligned byte addresses.
 */
package port_mux_pkg;
    // register byte offsets
    localparam logic [3:0] OFF_DATA = 4'h0; // port data latch
    localparam logic [3:0] OFF_DIR = 4'h4; // port_direction_reg
    localparam logic [3:0] OFF_MODE = 4'h8; // port_pin_mode_reg
    localparam logic [3:0] OFF_PULL = 4'hC; // port_pullup_ctrl_reg
    // field positions inside port_pin_mode_reg
    localparam int BIT_SER1_CLK = 0; // ser1_clock_pin_select
    localparam int BIT_SER1_DIN = 1; // ser1_din_pin_select
    localparam int BIT_SER1_DOUT = 2; // ser1_dout_pin_select
    localparam int BIT_SER2_CLK = 3; // ser2_clock_pin_select
    // reset values
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic [7:0] RST_PULL = 8'h00;
    localparam logic [7:0] RST_DATA = 8'h00;
    // clock source code that turns serial unit 2 clock into an input
    localparam logic [2:0] SER2_EXT_CLK = 3'h7;
    // operating modes of the chip
    typedef enum logic [2:0] {
        MODE_ACTIVE, MODE_SUBACTIVE, MODE_SLEEP, MODE_SUBSLEEP, MODE_WATCH, MODE_STANDBY
    } op_mode_type;
endpackage

// ===== testbench/pin_board_model.sv
/*
 * board side of port three: resolves each pin from the mux, an outside
 * driver and the pull-up. assumes one clk_sys domain.
 */
`timescale 1ns/1ps
module pin_board_model (
    input wire logic clk_sys,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pullup_on,
    input wire logic [7:0] ext_level,
    input wire logic [7:0] ext_oe,
    output logic [7:0] pin_in
);
    // a floating pin wanders so that no stale level passes for a real one
    logic [7:0] float_q = 8'h55;
    always_ff @(posedge clk_sys) begin
        float_q <= ~pin_in;
    end
    // pin level: chip driver, then board driver, then pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else if (ext_oe[i])
                pin_in[i] = ext_level[i];
            else if (pullup_on[i])
                pin_in[i] = 1'h1;
            else
                pin_in[i] = float_q[i];
        end
    end
endmodule // pin_board_model

// ===== testbench/port_three_pin_mux_bench.sv
/*
 * self-checking bench for the port three pin mux over avalon-mm.
 * assumes the mux package and the board model are compiled first.
 */
`timescale 1ns/1ps
module port_three_pin_mux_bench;
    logic clk_sys = 1'h0; // 200 MHz
    logic rst = 1'h1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    port_mux_pkg::op_mode_type op_mode = port_mux_pkg::MODE_ACTIVE;
    logic [7:0] pin_in, pin_out, pin_oe, pullup_on;
    logic [7:0] ext_level = 8'h02; // board drives pin one only
    logic [7:0] ext_oe = 8'h02;
    logic s1_src = 1'h0, s1_clk = 1'h1, s1_dout = 1'h0, s2_clk = 1'h1;
    logic [2:0] s2_src = 3'h0;
    logic ser1_clk_in, ser1_din, ser2_clk_in;
    int mismatches = 0;
    int check_count = 0;
    logic [31:0] rd; // last read data
    always #2.5 clk_sys = ~clk_sys;
    port_three_pin_mux uut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .op_mode(op_mode), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
        .ser1_clock_source_bit(s1_src), .ser1_clk_out(s1_clk), .ser1_clk_in(ser1_clk_in),
        .ser1_dout(s1_dout), .ser1_din(ser1_din), .ser2_clock_source_bits(s2_src),
        .ser2_clk_out(s2_clk), .ser2_clk_in(ser2_clk_in));
    pin_board_model board (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_on(pullup_on), .ext_level(ext_level), .ext_oe(ext_oe), .pin_in(pin_in));
    // compare one byte and count it
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one avalon transfer; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] addr, input logic [7:0] data);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= addr;
        avs_writedata <= {24'h0, data};
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'h0 && n < 50) begin
            n++;
            @(posedge clk_sys);
        end
        if (n == 50) begin
            mismatches++; // slave never answered
            finish_test;
        end
        rd = avs_readdata;
        avs_write <= 1'h0;
        avs_read <= 1'h0;
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // watchdog: the tests need well under a thousand cycles
    initial begin
        #20000;
        mismatches++;
        finish_test;
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        chk("oe in reset", 8'h00, pin_oe);
        rst <= 1'h0;
        bus(0, port_mux_pkg::OFF_MODE, 8'h00);
        chk("mode reset", 8'h00, rd[7:0]);
        bus(0, port_mux_pkg::OFF_PULL, 8'h00);
        chk("pull reset", 8'h00, rd[7:0]);
        chk("pullup after reset", 8'h00, pullup_on);
        bus(1, 4'h1, 8'hFF); // unmapped place ignores writes
        bus(0, 4'h1, 8'h00);
        chk("unmapped", 8'h00, rd[7:0]);
        $display("test reset done");
        bus(1, port_mux_pkg::OFF_DIR, 8'h0F);
        bus(1, port_mux_pkg::OFF_PULL, 8'hFF);
        @(negedge clk_sys);
        chk("pullup", 8'hF0, pullup_on);
        bus(1, port_mux_pkg::OFF_DIR, 8'hA5);
        bus(1, port_mux_pkg::OFF_DATA, 8'h00);
        @(negedge clk_sys);
        chk("pullup", 8'h5A, pullup_on);
        chk("gpio oe", 8'hA5, pin_oe);
        repeat (4) @(posedge clk_sys);
        bus(0, port_mux_pkg::OFF_DATA, 8'h00);
        chk("pin levels", 8'h5A, rd[7:0]);
        $display("test pullup done");
        bus(1, port_mux_pkg::OFF_DIR, 8'hFF);
        bus(1, port_mux_pkg::OFF_MODE, 8'h0F);
        // both clock sources of unit 1 against unit 2 source codes 6 and 7
        for (int k = 0; k < 4; k++) begin
            @(posedge clk_sys);
            s1_src <= k[0];
            s2_src <= k[1] ? 3'h7 : 3'h6;
            s1_dout <= ~k[0];
            @(negedge clk_sys);
            chk("serial oe", {4'hF, ~k[1], 1'h1, 1'h0, ~k[0]}, pin_oe);
            chk("serial out", {4'h0, ~k[1], ~k[0], 1'h0, ~k[0]}, pin_out & pin_oe & 8'h0F);
        end
        chk("serial din", 8'h01, {7'h0, ser1_din});
        $display("test serial done");
        bus(1, port_mux_pkg::OFF_MODE, 8'h00);
        @(negedge clk_sys);
        chk("serial in off", 8'h00, {6'h0, ser1_clk_in, ser2_clk_in});
        bus(1, port_mux_pkg::OFF_DATA, 8'h3C);
        @(posedge clk_sys);
        op_mode <= port_mux_pkg::MODE_SLEEP;
        bus(1, port_mux_pkg::OFF_DATA, 8'hC3);
        @(negedge clk_sys);
        chk("sleep hold", 8'h3C, pin_out);
        @(posedge clk_sys);
        op_mode <= port_mux_pkg::MODE_STANDBY;
        bus(1, port_mux_pkg::OFF_DIR, 8'h0F);
        @(negedge clk_sys);
        chk("standby oe", 8'h00, pin_oe);
        chk("standby high", 8'hF0, pin_in & pullup_on);
        @(posedge clk_sys);
        op_mode <= port_mux_pkg::MODE_ACTIVE;
        @(negedge clk_sys);
        chk("active out", 8'h03, pin_out & pin_oe);
        $display("test modes done");
        finish_test;
    end
endmodule // port_three_pin_mux_bench
